/* design/alarm_relay.sv */
/*
 * Alarm evaluation for seventeen inputs, alarm indicator, display
 * alternation flag, beeper and two relay coil drivers, behind an APB slave.
 * Assumes readings and zone relay states come from logic on pclk.
 */
// The APB slave port and the register addresses were left to the implementer.
// Behaviour
// - Reading above an input's upper threshold raises its high alarm.
// - Reading below an input's lower threshold raises its low alarm.
// - Readings from any source compared; thresholds and options kept per input.
// - Reset: lower threshold 0 K, upper 1000 K, alarm disabled.
// - Indicator steady when an enabled visible alarm exists and none active.
// - Indicator blinks while any visible alarm is active.
// - Displayed input in alarm alternates between status message and reading.
// - Beeper sounds when an enabled audible alarm is active.
// - Latching alarm stays set until operator confirms reset.
// - Yes clears latched alarms; no keeps them and requests setup menu.
// - Non-latching alarm follows the reading with dead-band hysteresis.
// - Non-latching high alarm clears at upper threshold minus dead band.
// - Non-latching low alarm clears at lower threshold plus dead band.
// - Reset: latching off, dead band 1.0000 K per input.
// - Two relays, each with its own mode and alarm input.
// - Off mode keeps the coil de-energized.
// - On mode keeps the coil energized.
// - Alarm mode following low energizes on low alarm.
// - Alarm mode following high energizes on high alarm.
// - Alarm mode following both energizes on either alarm.
// - Zone mode takes the active zone's relay state of selected output.
// - Per-relay selector picks sample or warm-up output zones.
`timescale 1ns/1ps
`default_nettype none

module alarm_relay
	import alarm_relay_pkg::*;
#(
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                reading_valid,
	input  wire logic [4:0]          reading_chan,
	input  wire logic [31:0]         reading_value,
	input  wire logic [1:0]          sample_zone_relay,
	input  wire logic [1:0]          warmup_zone_relay,
	output logic                     alarm_led,
	output logic                     display_alt,
	output logic                     beeper,
	output logic [1:0]               relay_coil,
	output logic                     setup_req
);
	import alarm_relay_pkg::*;

	// ---------------------------------------------------------------
	// Checks and helpers
	// ---------------------------------------------------------------
	if (BLINK_CYCLES < 2 || BLINK_CYCLES > 32'h7FFF_FFFF) begin : g_chk
		$error("BLINK_CYCLES out of range");
	end

	// Non-latching high alarm with hysteresis
	function automatic logic hi_next(input logic cur, input logic [31:0] v,
			input logic [31:0] thr, input logic [31:0] db);
		logic [32:0] rel;
		rel = {1'b0, thr} - {1'b0, db};
		if (!cur)
			hi_next = (v > thr);
		else
			hi_next = !(rel[32] == 1'b0 && {1'b0, v} <= rel);
	endfunction : hi_next

	// Non-latching low alarm with hysteresis
	function automatic logic lo_next(input logic cur, input logic [31:0] v,
			input logic [31:0] thr, input logic [31:0] db);
		logic [32:0] rel;
		rel = {1'b0, thr} + {1'b0, db};
		if (!cur)
			lo_next = (v < thr);
		else
			lo_next = ({1'b0, v} < rel);
	endfunction : lo_next

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [3:0]              cfg_ff    [NUM_INPUTS];
	logic [31:0]             low_ff    [NUM_INPUTS];
	logic [31:0]             high_ff   [NUM_INPUTS];
	logic [31:0]             dband_ff  [NUM_INPUTS];
	logic [NUM_INPUTS-1:0]   hi_ff;
	logic [NUM_INPUTS-1:0]   lo_ff;
	logic [15:0]             rly_ff    [2];
	logic [4:0]              disp_ff;
	logic [31:0]             prdata_ff;
	logic                    pready_ff;
	logic                    pslverr_ff;
	logic [31:0]             blink_cnt_ff;
	logic                    blink_ff;
	logic                    led_ff;
	logic                    alt_ff;
	logic                    beep_ff;
	logic [1:0]              coil_ff;
	logic                    setup_ff;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic                    acc;
	logic                    wr;
	logic                    in_win;
	logic [11:0]             in_off;
	logic [4:0]              in_ch;
	logic [1:0]              in_word;
	logic                    mapped;
	logic [31:0]             rd_val;

	// Access completes when ready has been raised
	assign acc     = psel && penable && pready_ff;
	assign wr      = acc && pwrite && mapped;
	assign in_win  = (paddr >= OFS_IN_BASE) && (paddr < OFS_IN_END);
	assign in_off  = paddr - OFS_IN_BASE;
	assign in_ch   = in_off[IN_STRIDE_SH +: CH_W];
	assign in_word = in_off[3:2];

	// Address map and read mux
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end else if (in_win) begin
			unique case (in_word)
				IW_CFG:   rd_val = {28'h000_0000, cfg_ff[in_ch]};
				IW_LOW:   rd_val = low_ff[in_ch];
				IW_HIGH:  rd_val = high_ff[in_ch];
				IW_DBAND: rd_val = dband_ff[in_ch];
			endcase
		end else begin
			unique case (paddr)
				OFS_HI_STAT:  rd_val = {15'h0000, hi_ff};
				OFS_LO_STAT:  rd_val = {15'h0000, lo_ff};
				OFS_ACK:      rd_val = 32'h0000_0000;
				OFS_DISP:     rd_val = {27'h000_0000, disp_ff};
				OFS_RELAY1:   rd_val = {16'h0000, rly_ff[0]};
				OFS_RELAY2:   rd_val = {16'h0000, rly_ff[1]};
				OFS_OUT_STAT: rd_val = {27'h000_0000, coil_ff, beep_ff, alt_ff, led_ff};
				default:      mapped = 1'b0;
			endcase
		end
	end

	// One wait state, then ready with data or error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			prdata_ff  <= (!pwrite && mapped) ? rd_val : 32'h0000_0000;
			pslverr_ff <= !mapped;
		end else begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Per-input settings
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_INPUTS; i++) begin
				cfg_ff[i]   <= CFG_RST;
				low_ff[i]   <= LOW_RST;
				high_ff[i]  <= HIGH_RST;
				dband_ff[i] <= DBAND_RST;
			end
		end else if (wr && in_win) begin
			unique case (in_word)
				IW_CFG:   cfg_ff[in_ch]   <= pwdata[3:0];
				IW_LOW:   low_ff[in_ch]   <= pwdata;
				IW_HIGH:  high_ff[in_ch]  <= pwdata;
				IW_DBAND: dband_ff[in_ch] <= pwdata;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Relay and display settings
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < 2; r++) begin
				rly_ff[r] <= {2'b00, FOL_BOTH, 3'h0, RLY_IN_RST, 2'b00, RM_OFF};
			end
			disp_ff <= 5'h00;
		end else if (wr) begin
			if (paddr == OFS_RELAY1)
				rly_ff[0] <= pwdata[15:0];
			if (paddr == OFS_RELAY2)
				rly_ff[1] <= pwdata[15:0];
			if (paddr == OFS_DISP)
				disp_ff <= pwdata[4:0];
		end
	end

	// ---------------------------------------------------------------
	// Alarm evaluation
	// ---------------------------------------------------------------
	logic                    ack_yes;
	logic                    ack_no;
	logic [NUM_INPUTS-1:0]   nxt_hi;
	logic [NUM_INPUTS-1:0]   nxt_lo;

	assign ack_yes = wr && (paddr == OFS_ACK) && pwdata[ACK_YES];
	assign ack_no  = wr && (paddr == OFS_ACK) && pwdata[ACK_NO] && !pwdata[ACK_YES];

	// New alarm states; a set in the same cycle as the yes clear wins
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			nxt_hi[i] = hi_ff[i];
			nxt_lo[i] = lo_ff[i];
			if (ack_yes && cfg_ff[i][CFG_LATCH]) begin
				nxt_hi[i] = 1'b0;
				nxt_lo[i] = 1'b0;
			end
			if (!cfg_ff[i][CFG_EN]) begin
				nxt_hi[i] = 1'b0;
				nxt_lo[i] = 1'b0;
			end else if (reading_valid && reading_chan == i[4:0]) begin
				if (cfg_ff[i][CFG_LATCH]) begin
					if (reading_value > high_ff[i])
						nxt_hi[i] = 1'b1;
					if (reading_value < low_ff[i])
						nxt_lo[i] = 1'b1;
				end else begin
					nxt_hi[i] = hi_next(hi_ff[i], reading_value, high_ff[i],
						dband_ff[i]);
					nxt_lo[i] = lo_next(lo_ff[i], reading_value, low_ff[i],
						dband_ff[i]);
				end
			end
		end
	end

	// Alarm state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_ff <= '0;
			lo_ff <= '0;
		end else begin
			hi_ff <= nxt_hi;
			lo_ff <= nxt_lo;
		end
	end

	// Setup menu request when the operator answers no
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			setup_ff <= 1'b0;
		else
			setup_ff <= ack_no;
	end

	// ---------------------------------------------------------------
	// Blink divider
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= 1'b0;
		end else if (blink_cnt_ff == 32'(BLINK_CYCLES - 1)) begin
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= !blink_ff;
		end else begin
			blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
		end
	end

	// ---------------------------------------------------------------
	// Annunciators
	// ---------------------------------------------------------------
	logic                    any_vis_en;
	logic                    any_vis_act;
	logic                    any_aud_act;
	logic                    disp_act;

	always_comb begin
		any_vis_en  = 1'b0;
		any_vis_act = 1'b0;
		any_aud_act = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (cfg_ff[i][CFG_EN] && cfg_ff[i][CFG_VIS])
				any_vis_en = 1'b1;
			if (cfg_ff[i][CFG_VIS] && (hi_ff[i] || lo_ff[i]))
				any_vis_act = 1'b1;
			if (cfg_ff[i][CFG_EN] && cfg_ff[i][CFG_AUD] && (hi_ff[i] || lo_ff[i]))
				any_aud_act = 1'b1;
		end
		disp_act = (disp_ff < 5'(NUM_INPUTS)) && (hi_ff[disp_ff] || lo_ff[disp_ff]);
	end

	// Indicator, display alternation and beeper
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_ff  <= 1'b0;
			alt_ff  <= 1'b0;
			beep_ff <= 1'b0;
		end else begin
			if (any_vis_act)
				led_ff <= blink_ff;
			else
				led_ff <= any_vis_en;
			alt_ff  <= disp_act && blink_ff;
			beep_ff <= any_aud_act;
		end
	end

	// ---------------------------------------------------------------
	// Relay coils
	// ---------------------------------------------------------------
	logic [1:0]              nxt_coil;

	always_comb begin
		logic [4:0] ch;
		logic       h;
		logic       l;
		ch = 5'h00;
		h  = 1'b0;
		l  = 1'b0;
		for (int r = 0; r < 2; r++) begin
			ch = rly_ff[r][RLY_IN_LO +: CH_W];
			h  = (ch < 5'(NUM_INPUTS)) && hi_ff[ch];
			l  = (ch < 5'(NUM_INPUTS)) && lo_ff[ch];
			unique case (relay_mode_t'(rly_ff[r][RLY_MODE_LO +: 2]))
				RM_OFF: nxt_coil[r] = 1'b0;
				RM_ON:  nxt_coil[r] = 1'b1;
				RM_ALARM: begin
					unique case (rly_ff[r][RLY_FOL_LO +: 2])
						FOL_LOW:  nxt_coil[r] = l;
						FOL_HIGH: nxt_coil[r] = h;
						default:  nxt_coil[r] = l || h;
					endcase
				end
				RM_ZONE: begin
					if (rly_ff[r][RLY_SRC] == SRC_WARMUP)
						nxt_coil[r] = warmup_zone_relay[r];
					else
						nxt_coil[r] = sample_zone_relay[r];
				end
			endcase
		end
	end

	// Coil drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			coil_ff <= 2'b00;
		else
			coil_ff <= nxt_coil;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata     = prdata_ff;
	assign pready     = pready_ff;
	assign pslverr    = pslverr_ff;
	assign alarm_led  = led_ff;
	assign display_alt = alt_ff;
	assign beeper     = beep_ff;
	assign relay_coil = coil_ff;
	assign setup_req  = setup_ff;

endmodule : alarm_relay

`default_nettype wire

/* design/alarm_relay_pkg.sv */
/*
 * Constants for the input alarm and relay block: register offsets, field
 * positions, reset values, relay modes and timing counts.
 * Assumes readings are unsigned fixed point in units of 0.0001 K.
 */
package alarm_relay_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int          NUM_INPUTS   = 17;
	localparam int          CH_W         = 5;
	localparam int          VAL_W        = 32;
	localparam int          ADDR_W       = 12;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_HI_STAT  = 12'h000;
	localparam logic [11:0] OFS_LO_STAT  = 12'h004;
	localparam logic [11:0] OFS_ACK      = 12'h008;
	localparam logic [11:0] OFS_DISP     = 12'h00C;
	localparam logic [11:0] OFS_RELAY1   = 12'h010;
	localparam logic [11:0] OFS_RELAY2   = 12'h014;
	localparam logic [11:0] OFS_OUT_STAT = 12'h018;
	localparam logic [11:0] OFS_IN_BASE  = 12'h100;
	localparam logic [11:0] OFS_IN_END   = 12'h210;
	localparam int          IN_STRIDE_SH = 4;
	// Word inside a per-input block
	localparam logic [1:0]  IW_CFG       = 2'h0;
	localparam logic [1:0]  IW_LOW       = 2'h1;
	localparam logic [1:0]  IW_HIGH      = 2'h2;
	localparam logic [1:0]  IW_DBAND     = 2'h3;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int          CFG_EN       = 0;
	localparam int          CFG_VIS      = 1;
	localparam int          CFG_AUD      = 2;
	localparam int          CFG_LATCH    = 3;
	localparam int          ACK_YES      = 0;
	localparam int          ACK_NO       = 1;
	localparam int          RLY_MODE_LO  = 0;
	localparam int          RLY_SRC      = 2;
	localparam int          RLY_IN_LO    = 4;
	localparam int          RLY_FOL_LO   = 12;

	// ---------------------------------------------------------------
	// Encodings and reset values
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RM_OFF   = 2'b00,
		RM_ON    = 2'b01,
		RM_ALARM = 2'b10,
		RM_ZONE  = 2'b11
	} relay_mode_t;
	typedef enum logic [1:0] {
		FOL_LOW  = 2'b00,
		FOL_HIGH = 2'b01,
		FOL_BOTH = 2'b10
	} follow_t;
	localparam logic [0:0]  SRC_SAMPLE   = 1'b0;
	localparam logic [0:0]  SRC_WARMUP   = 1'b1;
	localparam logic [3:0]  CFG_RST      = 4'h2;
	localparam logic [31:0] LOW_RST      = 32'h0000_0000;
	localparam logic [31:0] HIGH_RST     = 32'h0098_9680;
	localparam logic [31:0] DBAND_RST    = 32'h0000_2710;
	localparam logic [4:0]  RLY_IN_RST   = 5'h01;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int          CLK_MHZ      = 100;
	localparam int          BLINK_MS     = 500;
	localparam int          BLINK_CYC    = BLINK_MS * 1000 * CLK_MHZ;

endpackage : alarm_relay_pkg

/* dv/alarm_relay_properties.sv */
/*
 * Checker for the alarm relay block: off, on and zone relay coil modes, quiet outputs before
 * setup and the operator no answer pulse.
 * Assumes it sees only the block's ports; bound to alarm_relay below.
 */
`timescale 1ns/1ps
`default_nettype none
module alarm_relay_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        reading_valid,
	input wire logic [4:0]  reading_chan,
	input wire logic [31:0] reading_value,
	input wire logic [1:0]  sample_zone_relay,
	input wire logic [1:0]  warmup_zone_relay,
	input wire logic        alarm_led,
	input wire logic        display_alt,
	input wire logic        beeper,
	input wire logic [1:0]  relay_coil,
	input wire logic        setup_req
);
	import alarm_relay_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       wr_done;
	logic       no_wr;
	logic       wrote_ff;
	logic [2:0] rcfg_ff [2];
	// Completed writes and operator no answers
	assign wr_done = psel && penable && pready && pwrite;
	assign no_wr   = wr_done && paddr == OFS_ACK && pwdata[1:0] == 2'b10;
	// Any write since reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) wrote_ff <= 1'b0;
		else if (wr_done) wrote_ff <= 1'b1;
	end
	// Shadow of relay mode and zone source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcfg_ff[0] <= 3'h0;
			rcfg_ff[1] <= 3'h0;
		end else if (wr_done && paddr == OFS_RELAY1) rcfg_ff[0] <= pwdata[2:0];
		else if (wr_done && paddr == OFS_RELAY2) rcfg_ff[1] <= pwdata[2:0];
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	reset_coil_a: assert property (!wrote_ff |-> relay_coil == 2'b00)
		else $error("relay energized before setup");
	quiet_beep_a: assert property (!wrote_ff |-> !beeper)
		else $error("beeper on before setup");
	quiet_led_a: assert property (!wrote_ff |-> !alarm_led)
		else $error("indicator lit before setup");
	quiet_alt_a: assert property (!wrote_ff |-> !display_alt)
		else $error("display alternates before setup");
	no_answer_a: assert property (no_wr |-> ##[1:2] setup_req)
		else $error("no answer gave no setup request");
	setup_cause_a: assert property ($rose(setup_req) |-> $past(no_wr) || $past(no_wr, 2))
		else $error("setup request without no answer");
	setup_pulse_a: assert property (setup_req |=> !setup_req)
		else $error("setup request longer than one cycle");
	for (genvar r = 0; r < 2; r++) begin : g_rly
		relay_off_a: assert property (rcfg_ff[r][1:0] == RM_OFF && $stable(rcfg_ff[r])
			|-> !relay_coil[r]) else $error("off relay energized");
		relay_on_a: assert property (rcfg_ff[r][1:0] == RM_ON && $stable(rcfg_ff[r])
			|-> relay_coil[r]) else $error("on relay not energized");
		relay_zone_a: assert property (rcfg_ff[r][1:0] == RM_ZONE && $stable(rcfg_ff[r])
			|-> relay_coil[r] == (rcfg_ff[r][2] ? $past(warmup_zone_relay[r])
			: $past(sample_zone_relay[r]))) else $error("zone relay wrong state");
	end
	cover property (no_wr);
	cover property (relay_coil == 2'b11);
	cover property ($rose(alarm_led));
	cover property (beeper && display_alt);
endmodule : alarm_relay_checker
bind alarm_relay alarm_relay_checker alarm_relay_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.reading_valid(reading_valid), .reading_chan(reading_chan),
	.reading_value(reading_value), .sample_zone_relay(sample_zone_relay),
	.warmup_zone_relay(warmup_zone_relay), .alarm_led(alarm_led),
	.display_alt(display_alt), .beeper(beeper), .relay_coil(relay_coil),
	.setup_req(setup_req));
`default_nettype wire

/* dv/reading_source.sv */
/*
 * Reading source partner: hands one reading per call to the alarm block.
 * Assumes the caller runs on pclk; released lines never show stale data.
 */
`timescale 1ns/1ps
`default_nettype none
module reading_source (
	input  wire logic        pclk,
	output logic             reading_valid,
	output logic [4:0]       reading_chan,
	output logic [31:0]      reading_value
);
	initial reading_valid = 1'b0;
	initial reading_chan = 5'h00;
	initial reading_value = 32'h0000_0000;
	// One-cycle reading pulse, then inverse of the last value
	task automatic send(input logic [4:0] ch, input logic [31:0] val);
		@(posedge pclk);
		reading_valid <= 1'b1;
		reading_chan  <= ch;
		reading_value <= val;
		@(posedge pclk);
		reading_valid <= 1'b0;
		reading_chan  <= ~ch;
		reading_value <= ~val;
	endtask : send
endmodule : reading_source
`default_nettype wire

/* dv/input_alarm_and_relay_logic_tb_top.sv */
/*
 * Self-checking bench for the alarm relay block: reset values, hysteresis
 * corners, latching, annunciators and random relay traffic.
 * Assumes the checker is bound and the reading source partner is present.
 */
`timescale 1ns/1ps
`default_nettype none
module input_alarm_and_relay_logic_tb_top;
	import alarm_relay_pkg::*;
	localparam int BLINK = 4;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rq, reading_value;
	logic [31:0] lo_t [17], hi_t [17], db_t [17], r_w [2];
	logic        pready, pslverr, re, reading_valid, alarm_led, display_alt, beeper, setup_req;
	logic [4:0]  reading_chan;
	logic [1:0]  sample_zone_relay = 2'b00, warmup_zone_relay = 2'b00, relay_coil;
	logic [16:0] hi_m = '0, lo_m = '0, en_m = '0, lat_m = '0;
	int          n_fail = 0, checks_done = 0, seed = 32'hF63E, n_setup = 0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (setup_req === 1'b1) n_setup <= n_setup + 1;
	alarm_relay #(.BLINK_CYCLES(BLINK)) alarm_relay_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .reading_valid(reading_valid),
		.reading_chan(reading_chan), .reading_value(reading_value),
		.sample_zone_relay(sample_zone_relay), .warmup_zone_relay(warmup_zone_relay),
		.alarm_led(alarm_led), .display_alt(display_alt), .beeper(beeper),
		.relay_coil(relay_coil), .setup_req(setup_req));
	reading_source reading_source_inst (.pclk(pclk), .reading_valid(reading_valid),
		.reading_chan(reading_chan), .reading_value(reading_value));
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic tally_and_finish;
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// APB transfer held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic cfgch(input int ch, input logic [3:0] c, input logic [31:0] l, h, d);
		logic [11:0] b;
		b = OFS_IN_BASE + 12'(ch * 16);
		wr(b, {28'h0, c});
		wr(b + 12'h004, l);
		wr(b + 12'h008, h);
		wr(b + 12'h00C, d);
		en_m[ch] = c[CFG_EN];
		lat_m[ch] = c[CFG_LATCH];
		lo_t[ch] = l;
		hi_t[ch] = h;
		db_t[ch] = d;
		if (!c[CFG_EN]) hi_m[ch] = 1'b0;
		if (!c[CFG_EN]) lo_m[ch] = 1'b0;
	endtask : cfgch
	// Reading plus the expected alarm states
	task automatic send(input int ch, input logic [31:0] v);
		reading_source_inst.send(5'(ch), v);
		if (ch < 17 && en_m[ch]) begin
			hi_m[ch] = (v > hi_t[ch]) | (hi_m[ch] & (lat_m[ch] | v > hi_t[ch] - db_t[ch]));
			lo_m[ch] = (v < lo_t[ch]) | (lo_m[ch] & (lat_m[ch] | v < lo_t[ch] + db_t[ch]));
		end
	endtask : send
	task automatic stat_chk;
		rd(OFS_HI_STAT);
		chk("hi_status", rq, {15'h0, hi_m});
		rd(OFS_LO_STAT);
		chk("lo_status", rq, {15'h0, lo_m});
	endtask : stat_chk
	function automatic logic cexp(input int r);
		logic [31:0] w;
		logic        h;
		logic        l;
		w = r_w[r];
		h = hi_m[w[8:4]];
		l = lo_m[w[8:4]];
		case (w[1:0])
			2'b00: return 1'b0;
			2'b01: return 1'b1;
			2'b10: return w[13:12] == 2'b00 ? l : (w[13:12] == 2'b01 ? h : h | l);
			default: return w[2] ? warmup_zone_relay[r] : sample_zone_relay[r];
		endcase
	endfunction : cexp
	// Counts indicator and alternation changes and beeper-on cycles over 20 cycles
	task automatic watch(output int nl, output int na, output int nb);
		logic pl;
		logic pa;
		nl = 0;
		na = 0;
		nb = 0;
		pl = alarm_led;
		pa = display_alt;
		repeat (20) begin
			@(negedge pclk);
			nl += (alarm_led !== pl);
			na += (display_alt !== pa);
			nb += (beeper === 1'b1);
			pl = alarm_led;
			pa = display_alt;
		end
	endtask : watch
	// Watchdog: roughly ten times the expected run
	initial begin
		#600_000;
		n_fail++;
		tally_and_finish();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		int          i, nl, na, nb;
		logic [31:0] v;
		logic [31:0] cv [8];
		cv = '{32'h7D1, 32'h7D0, 32'h76D, 32'h76C, 32'h7D0, 32'h3E7, 32'h44B, 32'h44C};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 17; i++) begin
			rd(OFS_IN_BASE + 12'(i * 16));
			chk("cfg_reset", rq, 32'h0000_0002);
			rd(OFS_IN_BASE + 12'(i * 16 + 4));
			chk("low_reset", rq, 32'h0000_0000);
			rd(OFS_IN_BASE + 12'(i * 16 + 8));
			chk("high_reset", rq, 32'h0098_9680);
			rd(OFS_IN_BASE + 12'(i * 16 + 12));
			chk("dband_reset", rq, 32'h0000_2710);
		end
		for (i = 0; i < 2; i++) begin
			rd(OFS_RELAY1 + 12'(i * 4));
			chk("relay_reset", rq, 32'h0000_2010);
			r_w[i] = 32'h0000_2010;
		end
		rd(12'h020);
		chk("unmapped", {re, rq[30:0]}, 32'h8000_0000);
		rd(12'h102);
		chk("misaligned", {31'h0, re}, 32'h0000_0001);
		wr(OFS_HI_STAT, 32'hFFFF_FFFF);
		send(5, 32'hFFFF_FFFF);
		stat_chk();
		cfgch(3, 4'h1, 32'h3E8, 32'h7D0, 32'h64);
		for (i = 0; i < 8; i++) begin
			send(3, cv[i]);
			stat_chk();
			chk("quiet", {30'h0, alarm_led, beeper}, 32'h0000_0000);
		end
		cfgch(3, 4'h9, 32'h3E8, 32'h7D0, 32'h64);
		send(3, 32'h7D1);
		send(3, 32'h5DC);
		stat_chk();
		i = n_setup;
		wr(OFS_ACK, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		chk("setup_req", 32'(n_setup - i), 32'h0000_0001);
		stat_chk();
		wr(OFS_ACK, 32'h0000_0001);
		hi_m &= ~lat_m;
		lo_m &= ~lat_m;
		stat_chk();
		cfgch(3, 4'h3, 32'h3E8, 32'h7D0, 32'h64);
		send(3, 32'h5DC);
		repeat (3) @(posedge pclk);
		watch(nl, na, nb);
		chk("led_steady", {alarm_led, 7'(nl), 8'(na), 8'(nb)}, 32'h0080_0000);
		cfgch(3, 4'h7, 32'h3E8, 32'h7D0, 32'h64);
		wr(OFS_DISP, 32'h0000_0003);
		send(3, 32'h7D1);
		repeat (3) @(posedge pclk);
		watch(nl, na, nb);
		chk("led_blink", {31'h0, nl >= 3}, 32'h0000_0001);
		chk("alt_blink", {31'h0, na >= 3}, 32'h0000_0001);
		chk("beeper", 32'(nb), 32'h0000_0014);
		wr(OFS_DISP, 32'h0000_0004);
		repeat (3) @(posedge pclk);
		watch(nl, na, nb);
		chk("alt_other", {na[30:0], display_alt}, 32'h0000_0000);
		for (i = 0; i < 17; i++) begin
			v = $random(seed);
			cfgch(i, {v[3:2], 1'b0, v[0] | v[1]}, {23'h0, v[12:4]}, {23'h1, v[21:13]},
				{25'h0, v[28:22]} + 32'h1);
		end
		for (i = 0; i < 300; i++) begin
			v = $random(seed);
			r_w[v[4]] = {18'h0, v[14:13], 3'h0, 5'(v[9:5] % 17), 1'b0, v[2:0]};
			wr(OFS_RELAY1 + {9'h0, v[4], 2'b00}, r_w[v[4]]);
			sample_zone_relay <= v[16:15];
			warmup_zone_relay <= v[18:17];
			if (v[22:19] == 4'h0) begin
				wr(OFS_ACK, 32'h0000_0001);
				hi_m &= ~lat_m;
				lo_m &= ~lat_m;
			end
			v = $random(seed);
			send(int'(v[27:23] % 21), {21'h0, v[10:0]});
			@(posedge pclk);
			@(negedge pclk);
			chk("coils", {30'h0, relay_coil}, {30'h0, cexp(1), cexp(0)});
			stat_chk();
		end
		tally_and_finish();
	end
endmodule : input_alarm_and_relay_logic_tb_top
`default_nettype wire
